// ===== logic/upt_pkg.sv
package upt_pkg;

  // ****************************************************
  // clock, defaults and register map
  // ****************************************************
  localparam int          CLK_HZ   = 100_000_000;
  localparam int          BAUD_DEF = 115_200;
  localparam logic [15:0] DIV_RST  = 16'(CLK_HZ / BAUD_DEF);
  localparam logic [31:0] TOUT_RST = 32'h0000_2710;
  localparam logic [31:0] CTRL_RST = 32'h0000_1000;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DIV  = 8'h04;
  localparam logic [7:0] A_TOUT = 8'h08;
  localparam logic [7:0] A_WORD = 8'h0c;
  localparam logic [7:0] A_PAT  = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_CNT  = 8'h18;

  // ****************************************************
  // control and word register field positions
  // ****************************************************
  localparam int C_ARM  = 0;
  localparam int C_MODE = 1;
  localparam int C_SRC  = 4;
  localparam int C_POL  = 5;
  localparam int C_MSB  = 6;
  localparam int C_PKT  = 7;
  localparam int C_NB   = 9;
  localparam int C_PAR  = 13;
  localparam int C_OP   = 16;
  localparam int C_LEN  = 18;
  localparam int W_END  = 0;
  localparam int W_POS  = 16;

  // ****************************************************
  // modes and records
  // ****************************************************
  typedef enum logic [2:0] {
    TM_START, TM_PKT, TM_DATA, TM_PAR, TM_BREAK, TM_STOP
  } upt_trig_t;
  typedef enum logic [2:0] {
    PAR_NONE, PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE, PAR_DC
  } upt_par_t;
  typedef enum logic [1:0] {PKT_NONE, PKT_END, PKT_TOUT} upt_pkt_t;
  typedef enum logic [1:0] {OP_EQ, OP_NE, OP_LT, OP_GT} upt_op_t;
  typedef enum logic [2:0] {
    WS_OK, WS_START, WS_STOP, WS_PAR, WS_SHORT
  } upt_wstate_t;

  typedef struct packed {
    logic [15:0] index;
    upt_wstate_t state;
    logic        err;
    logic [31:0] t_start;
    logic [31:0] t_stop;
    logic        src;
    logic [8:0]  value;
    logic [15:0] rate;
  } upt_rec_t;

endpackage

// ===== logic/upt_trigger.sv
`timescale 1ns/1ps
// What this block does
// - start-bit mode fires on first low bit after a stop bit.
// - packet-start mode fires at the first start bit of each packet.
// - data mode matches a pattern at a word position, several words long.
// - parity mode fires on parity mismatch, only when parity is configured.
// - break fires when line stays low longer than one whole word.
// - stop-error mode fires when the stop bit samples as 0.
// - triggers look at exactly one line, transmit or receive, by selection.
// - data mode applies a selectable comparison operator.
// - pattern words are taken most significant byte first.
// - a count of words is skipped before the pattern comparison.
// - the word offset counts only while packet detection is on.
// - each word yields index, state, start, stop, value and rate record.
// - a word cut off by capture end is marked insufficient length.
// - start, stop and parity bits get separate error indications.
// - each word is flagged correct or erroneous.
// - word length 5 to 8 bits, 9 bits only without parity.
// - packet ends after an end word or a minimum idle time.
// - odd parity bit is 1 for even ones count; even the reverse.
module upt_trigger #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  // sampled serial lines and capture window
  input  wire logic             tx_line_in,
  input  wire logic             rx_line_in,
  input  wire logic             acq_active_in,
  // register port
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic [31:0]      reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic      [31:0]      reg_rdata_out,
  // trigger and decoded records
  output logic                  trig_out,
  output logic                  rec_valid_out,
  output upt_pkg::upt_rec_t     rec_out
);

  if ((2 ** DIV_W) <= int'(upt_pkg::DIV_RST) || DIV_W > 16) begin : g_chk
    $error("DIV_W too narrow for the reset divider or above 16");
  end

  typedef enum {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BREAK, RX_WAITHI
  } upt_rx_t;

  // ****************************************************
  // registers
  // ****************************************************
  logic [31:0]        ctrl_r, tout_r, word_r, pat_r, rdata_r;
  logic [DIV_W-1:0]   div_r;
  logic [15:0]        tcnt_r;
  upt_rx_t            st_r;
  logic [DIV_W-1:0]   cnt_r;
  logic [3:0]         bitn_r;
  logic [8:0]         sh_r;
  logic               perr_r, serr_r, anyhi_r, brk_r, fire_r;
  logic [31:0]        time_r, tstart_r, idle_r;
  logic [15:0]        index_r;
  logic [7:0]         pos_r;
  logic [2:0]         match_r;
  logic               pktnew_r, recv_r;
  upt_pkg::upt_rec_t  rec_r;

  // ****************************************************
  // configuration decode
  // ****************************************************
  wire             armed   = ctrl_r[upt_pkg::C_ARM];
  wire [2:0]       mode    = ctrl_r[upt_pkg::C_MODE +: 3];
  wire             src_rx  = ctrl_r[upt_pkg::C_SRC];
  wire             pol_low = ctrl_r[upt_pkg::C_POL];
  wire             msb_1st = ctrl_r[upt_pkg::C_MSB];
  wire [1:0]       pkt     = ctrl_r[upt_pkg::C_PKT +: 2];
  wire [3:0]       nb_raw  = ctrl_r[upt_pkg::C_NB +: 4];
  wire [2:0]       par     = ctrl_r[upt_pkg::C_PAR +: 3];
  wire [1:0]       op      = ctrl_r[upt_pkg::C_OP +: 2];
  wire [2:0]       plen    = {1'b0, ctrl_r[upt_pkg::C_LEN +: 2]} + 3'h1;
  wire [8:0]       endword = word_r[upt_pkg::W_END +: 9];
  wire [7:0]       wpos    = word_r[upt_pkg::W_POS +: 8];
  wire [DIV_W-1:0] half    = div_r >> 1;
  wire             has_par = par != 3'(upt_pkg::PAR_NONE);
  // expected parity and the schemes that can fail
  wire par_chk = par == 3'(upt_pkg::PAR_ODD) ||
                 par == 3'(upt_pkg::PAR_EVEN) ||
                 par == 3'(upt_pkg::PAR_MARK) ||
                 par == 3'(upt_pkg::PAR_SPACE);
  // 5..8 bits, 9 only without parity, else 8
  wire nb_ok = (nb_raw >= 4'h5 && nb_raw <= 4'h8) ||
               (nb_raw == 4'h9 && !has_par);
  wire [3:0] nbits = nb_ok ? nb_raw : 4'h8;

  // ****************************************************
  // line selection and receiver datapath
  // ****************************************************
  // one line only, by source selection
  wire line  = src_rx ? rx_line_in : tx_line_in;
  wire bit_v = pol_low ? ~line : line;
  wire tick  = cnt_r == '0;
  wire last_data = bitn_r == nbits - 4'h1;
  wire [8:0] sh_nxt = msb_1st ? {sh_r[7:0], bit_v} : {bit_v, sh_r[8:1]};
  wire [8:0] val_lsb = sh_r >> (4'h9 - nbits);
  wire [8:0] value = msb_1st ? (sh_r & ~(9'h1ff << nbits)) : val_lsb;
  wire ones_odd = ^value;
  wire exp_par = (par == 3'(upt_pkg::PAR_ODD))  ? ~ones_odd :
                 (par == 3'(upt_pkg::PAR_EVEN)) ?  ones_odd :
                 (par == 3'(upt_pkg::PAR_MARK));
  // start edge and mid-bit sample points
  wire start_ev = st_r == RX_IDLE && acq_active_in && !bit_v;
  wire stop_smp = st_r == RX_STOP && tick;
  wire cut = !acq_active_in && st_r != RX_IDLE &&
             st_r != RX_WAITHI && st_r != RX_BREAK;
  wire brk_ev = st_r == RX_BREAK && tick && !bit_v;

  // ****************************************************
  // receiver state machine
  // ****************************************************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_r    <= RX_IDLE;
      cnt_r   <= '0;
      bitn_r  <= 4'h0;
      sh_r    <= 9'h000;
      perr_r  <= 1'b0;
      serr_r  <= 1'b0;
      anyhi_r <= 1'b0;
    end else if (cut) begin
      st_r <= RX_WAITHI;
    end else begin
      cnt_r <= tick ? cnt_r : cnt_r - 1'b1;
      case (st_r)
        RX_IDLE: if (start_ev) begin
          st_r    <= RX_START;
          cnt_r   <= half;
          perr_r  <= 1'b0;
          anyhi_r <= 1'b0;
        end
        // start bit must still be low at its centre
        RX_START: if (tick) begin
          serr_r <= bit_v;
          st_r   <= RX_DATA;
          cnt_r  <= div_r;
          bitn_r <= 4'h0;
        end
        RX_DATA: if (tick) begin
          sh_r    <= sh_nxt;
          anyhi_r <= anyhi_r | bit_v;
          bitn_r  <= bitn_r + 4'h1;
          cnt_r   <= div_r;
          if (last_data) begin
            st_r <= has_par ? RX_PAR : RX_STOP;
          end
        end
        // parity compared after the data bits
        RX_PAR: if (tick) begin
          perr_r  <= par_chk && (bit_v != exp_par);
          anyhi_r <= anyhi_r | bit_v;
          st_r    <= RX_STOP;
          cnt_r   <= div_r;
        end
        // all-low word goes on to break watch
        RX_STOP: if (tick) begin
          cnt_r <= half;
          if (bit_v) begin
            st_r <= RX_IDLE;
          end else if (!anyhi_r && !serr_r) begin
            st_r <= RX_BREAK;
          end else begin
            st_r <= RX_WAITHI;
          end
        end
        RX_BREAK: if (bit_v) begin
          st_r <= RX_IDLE;
        end else if (tick) begin
          st_r <= RX_WAITHI;
        end
        RX_WAITHI: if (bit_v) begin
          st_r <= RX_IDLE;
        end
        default: st_r <= RX_IDLE;
      endcase
    end
  end

  // ****************************************************
  // time base, packet tracking and records
  // ****************************************************
  // end word or idle timeout opens a new packet
  wire tout_hit = pkt == 2'(upt_pkg::PKT_TOUT) && st_r == RX_IDLE &&
                  idle_r >= tout_r;
  wire end_hit  = pkt == 2'(upt_pkg::PKT_END) && stop_smp &&
                  value == endword;
  upt_pkg::upt_wstate_t wst;
  assign wst = cut                 ? upt_pkg::WS_SHORT :
               serr_r              ? upt_pkg::WS_START :
               !bit_v              ? upt_pkg::WS_STOP  :
               perr_r              ? upt_pkg::WS_PAR   :
                                     upt_pkg::WS_OK;
  wire rec_ev = stop_smp || cut;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      time_r   <= 32'h0000_0000;
      idle_r   <= 32'h0000_0000;
      tstart_r <= 32'h0000_0000;
      pktnew_r <= 1'b1;
      pos_r    <= 8'h00;
      index_r  <= 16'h0000;
    end else begin
      time_r <= time_r + 32'h1;
      idle_r <= (st_r != RX_IDLE) ? 32'h0 :
                (tout_hit ? idle_r : idle_r + 32'h1);
      if (tout_hit || end_hit) begin
        pktnew_r <= 1'b1;
      end
      if (start_ev) begin
        tstart_r <= time_r;
        pktnew_r <= 1'b0;
        pos_r    <= pktnew_r ? 8'h00 : pos_r + 8'h01;
      end
      if (rec_ev) begin
        index_r <= index_r + 16'h1;
      end
    end
  end

  // one record per word; error flag
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      recv_r <= 1'b0;
      rec_r  <= '0;
    end else begin
      recv_r <= rec_ev;
      if (rec_ev) begin
        rec_r.index   <= index_r;
        rec_r.state   <= wst;
        rec_r.err     <= wst != upt_pkg::WS_OK;
        rec_r.t_start <= tstart_r;
        rec_r.t_stop  <= time_r;
        rec_r.src     <= src_rx;
        rec_r.value   <= value;
        rec_r.rate    <= 16'(div_r);
      end
    end
  end

  // ****************************************************
  // data pattern comparison
  // ****************************************************
  // pattern word k is byte k from the top, MSB first
  wire [8:0] pword = {1'b0, pat_r[31 - 8 * match_r -: 8]};
  wire cmp = (op == 2'(upt_pkg::OP_EQ)) ? value == pword :
             (op == 2'(upt_pkg::OP_NE)) ? value != pword :
             (op == 2'(upt_pkg::OP_LT)) ? value <  pword :
                                          value >  pword;
  // skip wpos words; only with packet detection
  wire [7:0] skip   = (pkt != 2'(upt_pkg::PKT_NONE)) ? wpos : 8'h00;
  wire [7:0] rel    = pos_r - skip;
  wire in_seq = (pkt == 2'(upt_pkg::PKT_NONE)) ||
                (pos_r >= skip && rel == {5'h00, match_r});
  wire word_ok = stop_smp && bit_v && !serr_r && !perr_r;
  // consecutive words all satisfy the comparison
  wire step = word_ok && in_seq && cmp;
  wire data_hit = step && (match_r + 3'h1 == plen);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !armed) begin
      match_r <= 3'h0;
    end else if (stop_smp) begin
      match_r <= (step && !data_hit) ? match_r + 3'h1 : 3'h0;
    end
  end

  // ****************************************************
  // trigger selection
  // ****************************************************
  logic hit;
  always_comb begin
    case (mode)
      // first low bit after a stop bit
      3'(upt_pkg::TM_START): hit = start_ev;
      // first start bit of a packet
      3'(upt_pkg::TM_PKT): hit = start_ev && pktnew_r &&
                                 pkt != 2'(upt_pkg::PKT_NONE);
      3'(upt_pkg::TM_DATA): hit = data_hit;
      // parity trigger only with a parity scheme
      3'(upt_pkg::TM_PAR): hit = stop_smp && perr_r && par_chk;
      3'(upt_pkg::TM_BREAK): hit = brk_ev;
      3'(upt_pkg::TM_STOP): hit = stop_smp && !bit_v;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fire_r <= 1'b0;
      tcnt_r <= 16'h0000;
      brk_r  <= 1'b0;
    end else begin
      fire_r <= armed && hit;
      brk_r  <= brk_ev;
      tcnt_r <= tcnt_r + {15'h0000, armed && hit};
    end
  end

  // ****************************************************
  // register port
  // ****************************************************
  wire wr_ctrl = reg_wr_in && reg_addr_in == upt_pkg::A_CTRL;
  // settings locked while armed, only arm can change
  wire wr_cfg  = reg_wr_in && !armed;
  wire [31:0] stat = {tcnt_r, 10'h000, brk_r, rec_r.state,
                      st_r != RX_IDLE, armed};

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl_r <= upt_pkg::CTRL_RST;
      div_r  <= DIV_W'(upt_pkg::DIV_RST);
      tout_r <= upt_pkg::TOUT_RST;
      word_r <= 32'h0000_0000;
      pat_r  <= 32'h0000_0000;
    end else if (wr_ctrl && armed) begin
      ctrl_r[upt_pkg::C_ARM] <= reg_wdata_in[upt_pkg::C_ARM];
    end else if (wr_cfg) begin
      case (reg_addr_in)
        upt_pkg::A_CTRL: ctrl_r <= reg_wdata_in;
        upt_pkg::A_DIV:  div_r  <= reg_wdata_in[DIV_W-1:0];
        upt_pkg::A_TOUT: tout_r <= reg_wdata_in;
        upt_pkg::A_WORD: word_r <= reg_wdata_in;
        upt_pkg::A_PAT:  pat_r  <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !reg_rd_in) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      case (reg_addr_in)
        upt_pkg::A_CTRL: rdata_r <= ctrl_r;
        upt_pkg::A_DIV:  rdata_r <= 32'(div_r);
        upt_pkg::A_TOUT: rdata_r <= tout_r;
        upt_pkg::A_WORD: rdata_r <= word_r;
        upt_pkg::A_PAT:  rdata_r <= pat_r;
        upt_pkg::A_STAT: rdata_r <= stat;
        upt_pkg::A_CNT:  rdata_r <= {16'h0000, index_r};
        default:         rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // outputs
  assign reg_rdata_out = rdata_r;
  assign trig_out      = fire_r;
  assign rec_valid_out = recv_r;
  assign rec_out       = rec_r;

  // ****************************************************
  // assertions
  // ****************************************************
  a_trig_single: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    trig_out |=> !trig_out) else $error("trigger longer than one cycle");
  a_cfg_frozen: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    armed && reg_wr_in && reg_addr_in == upt_pkg::A_DIV |=> $stable(div_r))
    else $error("divider changed while armed");
  a_start_fire: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    armed && start_ev && mode == 3'(upt_pkg::TM_START) |=> trig_out)
    else $error("start bit did not trigger");
  a_src_line: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    st_r == RX_IDLE && acq_active_in && (src_rx ? rx_line_in : tx_line_in)
    == pol_low |=> st_r == RX_START) else $error("selected line ignored");
  a_stop_trig: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    trig_out && $past(mode) == 3'(upt_pkg::TM_STOP) |->
    rec_valid_out && rec_out.state == upt_pkg::WS_STOP)
    else $error("stop trigger without stop error");
  a_par_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    trig_out && $past(mode) == 3'(upt_pkg::TM_PAR) |-> $past(par_chk))
    else $error("parity trigger without parity scheme");
  a_break_low: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    brk_ev |-> $past(st_r, 2) != RX_IDLE && !bit_v && $past(!bit_v))
    else $error("break on a high line");
  a_short_rec: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cut |=> rec_valid_out && rec_out.state == upt_pkg::WS_SHORT && rec_out.err)
    else $error("cut word not marked short");
  a_rec_err: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    rec_valid_out |-> rec_out.err == (rec_out.state != upt_pkg::WS_OK))
    else $error("error flag disagrees with state");

endmodule

// ===== tb/upt_trigger_tb.sv
`timescale 1ns/1ps
module upt_trigger_tb;
  // ****************************************************
  // bench signals and model state
  // ****************************************************
  localparam logic [15:0] DIVV = 16'h000f;
  localparam int          BITC = 16;
  logic              clk_sys_in;
  logic              rst_in;
  logic              acq_active_in;
  logic              reg_wr_in;
  logic              reg_rd_in;
  logic [7:0]        reg_addr_in;
  logic [31:0]       reg_wdata_in;
  logic [31:0]       reg_rdata_out;
  logic              tx_line;
  logic              rx_line;
  logic              trig_out;
  logic              rec_valid_out;
  upt_pkg::upt_rec_t rec_out;
  int                miscompares;
  int                total_checks;
  int                trig_cnt;
  int                base;
  int                i;
  int                exp_q[$];
  logic [31:0]       rec_idx = 32'h0;
  logic [31:0]       seed;
  bit                src_sel;

  upt_uart_model u_far (
    .clk_in      (clk_sys_in),
    .tx_line_out (tx_line),
    .rx_line_out (rx_line)
  );

  upt_trigger dut (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .tx_line_in    (tx_line),
    .rx_line_in    (rx_line),
    .acq_active_in (acq_active_in),
    .reg_addr_in   (reg_addr_in),
    .reg_wdata_in  (reg_wdata_in),
    .reg_wr_in     (reg_wr_in),
    .reg_rd_in     (reg_rd_in),
    .reg_rdata_out (reg_rdata_out),
    .trig_out      (trig_out),
    .rec_valid_out (rec_valid_out),
    .rec_out       (rec_out)
  );

  // free-running clock
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // ****************************************************
  // compare, bus and stimulus tasks
  // ****************************************************
  task automatic summarize;
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_num(input logic [31:0] got, input logic [31:0] ex);
    total_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask

  // short words keep only state, source and rate
  task automatic chk_rec(input upt_pkg::upt_rec_t r, input int e);
    logic [31:0] got;
    logic [31:0] ex;
    logic        sh;
    sh  = (e[11:9] == 3'(upt_pkg::WS_SHORT));
    got = {r.rate, 2'h0, r.src, r.state, sh ? 10'h0 : {r.err, r.value}};
    ex  = {DIVV, 2'h0, e[12], e[11:9],
           sh ? 10'h0 : {e[11:9] != 3'h0, e[8:0]}};
    chk_num(got, ex);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b0;
    #1;
    chk_num(reg_rdata_out, ex);
  endtask

  // disarm, load word setup and pattern, then write control
  task automatic cfg(input logic [31:0] c, input logic [31:0] w,
                     input logic [31:0] p);
    wr(upt_pkg::A_CTRL, 32'h0);
    wr(upt_pkg::A_WORD, w);
    wr(upt_pkg::A_PAT, p);
    wr(upt_pkg::A_CTRL, c);
    src_sel = c[4];
  endtask

  // control word for 8 data bits from mode, source and options
  function automatic logic [31:0] mk(input int md, input int s, input int m,
                                     input int pk, input int pa, input int o);
    return 32'(md * 2 + s * 16 + m * 64 + pk * 128 + pa * 8192 + o * 65536)
           + 32'h0000_1000;
  endfunction

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // send on the selected line and queue the expected record
  task automatic send_word(input logic [7:0] v, input int pa, input bit bp,
                           input bit bs, input bit m);
    int st;
    st = bs ? 2 : (bp ? 3 : 0);
    exp_q.push_back(int'(v) | (st << 9) | (int'(src_sel) << 12));
    u_far.send(src_sel, {1'b0, v}, 8, pa, m, bp, bs);
  endtask

  // ****************************************************
  // monitors
  // ****************************************************
  // trigger pulses counted once per high cycle
  always @(posedge clk_sys_in) begin
    if (trig_out === 1'b1) begin
      trig_cnt <= trig_cnt + 1;
    end
  end

  // every record against the queued expectation and its index
  always @(posedge clk_sys_in) begin
    if (rec_valid_out === 1'b1) begin
      chk_num(32'(rec_out.index), rec_idx);
      rec_idx <= rec_idx + 32'h1;
      if (exp_q.size() > 0) begin
        chk_rec(rec_out, exp_q.pop_front());
      end else begin
        chk_num(32'h0, 32'h1);
      end
    end
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    miscompares++;
    summarize();
  end

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    rst_in = 1'b1; acq_active_in = 1'b1; reg_wr_in = 1'b0;
    reg_rd_in = 1'b0; reg_addr_in = 8'h00; reg_wdata_in = 32'h0;
    miscompares = 0; total_checks = 0; trig_cnt = 0;
    seed = 32'h30e1; src_sel = 1'b0;
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd(upt_pkg::A_CTRL, upt_pkg::CTRL_RST);
    rd(upt_pkg::A_DIV, 32'(upt_pkg::DIV_RST));
    rd(upt_pkg::A_TOUT, upt_pkg::TOUT_RST);
    rd(upt_pkg::A_PAT, 32'h0);
    rd(8'h1c, 32'h0);
    wr(upt_pkg::A_DIV, 32'(DIVV));
    cfg(mk(0, 0, 0, 0, 0, 0) | 32'h1, 32'h0, 32'h0);
    wr(upt_pkg::A_DIV, 32'h3);
    rd(upt_pkg::A_DIV, 32'(DIVV));
    base = trig_cnt;
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      send_word(seed[7:0], 0, 0, 0, 0);
    end
    u_far.send(1'b1, 9'h055, 8, 0, 0, 0, 0);
    chk_num(trig_cnt - base, 4);
    cfg(mk(0, 1, 0, 0, 0, 0), 32'h0, 32'h0);
    base = trig_cnt;
    send_word(8'h3c, 0, 0, 0, 0);
    chk_num(trig_cnt - base, 0);
    cfg(mk(5, 1, 0, 0, 0, 0) | 32'h1, 32'h0, 32'h0);
    base = trig_cnt;
    send_word(8'h81, 0, 0, 0, 0);
    send_word(8'h42, 0, 0, 1, 0);
    chk_num(trig_cnt - base, 1);
    for (i = 1; i < 5; i++) begin
      cfg(mk(3, 0, 0, 0, i, 0) | 32'h1, 32'h0, 32'h0);
      base = trig_cnt;
      send_word(8'h5b, i, 0, 0, 0);
      send_word(8'h5b, i, 1, 0, 0);
      chk_num(trig_cnt - base, 1);
    end
    cfg(mk(4, 0, 0, 0, 0, 0) | 32'h1, 32'h0, 32'h0);
    base = trig_cnt;
    exp_q.push_back(32'h400);
    u_far.hold(1'b0, 1'b0, 12 * BITC);
    u_far.hold(1'b0, 1'b1, 3 * BITC);
    chk_num(trig_cnt - base, 1);
    for (i = 0; i < 4; i++) begin
      cfg(mk(2, 0, 0, 0, 0, i) | 32'h1, 32'h0, 32'h4000_0000);
      base = trig_cnt;
      send_word(8'h30, 0, 0, 0, 0);
      chk_num(trig_cnt - base, 32'(i == 1 || i == 2));
    end
    cfg(mk(2, 0, 1, 0, 0, 0) | 32'h4_0001, 32'h0, 32'h7211_0000);
    base = trig_cnt;
    send_word(8'h11, 0, 0, 0, 1);
    send_word(8'h72, 0, 0, 0, 1);
    send_word(8'h11, 0, 0, 0, 1);
    chk_num(trig_cnt - base, 1);
    cfg(mk(2, 0, 0, 1, 0, 0) | 32'h1, 32'h0002_000a, 32'h7200_0000);
    send_word(8'h0a, 0, 0, 0, 0);
    base = trig_cnt;
    send_word(8'h72, 0, 0, 0, 0);
    send_word(8'h11, 0, 0, 0, 0);
    send_word(8'h72, 0, 0, 0, 0);
    send_word(8'h0a, 0, 0, 0, 0);
    chk_num(trig_cnt - base, 1);
    cfg(mk(2, 0, 0, 0, 0, 0) | 32'h1, 32'h0002_000a, 32'h7200_0000);
    base = trig_cnt;
    send_word(8'h72, 0, 0, 0, 0);
    send_word(8'h11, 0, 0, 0, 0);
    chk_num(trig_cnt - base, 1);
    cfg(mk(1, 0, 0, 1, 0, 0) | 32'h1, 32'h0000_000a, 32'h0);
    send_word(8'h0a, 0, 0, 0, 0);
    base = trig_cnt;
    send_word(8'h01, 0, 0, 0, 0);
    send_word(8'h0a, 0, 0, 0, 0);
    send_word(8'h03, 0, 0, 0, 0);
    chk_num(trig_cnt - base, 2);
    cfg(mk(1, 0, 0, 2, 0, 0), 32'h0, 32'h0);
    wr(upt_pkg::A_TOUT, 32'h40);
    wr(upt_pkg::A_CTRL, mk(1, 0, 0, 2, 0, 0) | 32'h1);
    base = trig_cnt;
    u_far.hold(1'b0, 1'b1, 100);
    send_word(8'h01, 0, 0, 0, 0);
    send_word(8'h02, 0, 0, 0, 0);
    u_far.hold(1'b0, 1'b1, 100);
    send_word(8'h03, 0, 0, 0, 0);
    chk_num(trig_cnt - base, 2);
    cfg(mk(0, 0, 0, 0, 0, 0) | 32'h1, 32'h0, 32'h0);
    exp_q.push_back(int'(upt_pkg::WS_SHORT) << 9);
    fork
      u_far.send(1'b0, 9'h0ff, 8, 0, 0, 0, 0);
      begin
        repeat (5 * BITC) @(posedge clk_sys_in);
        acq_active_in <= 1'b0;
      end
    join
    acq_active_in <= 1'b1;
    repeat (4 * BITC) @(posedge clk_sys_in);
    chk_num(32'(exp_q.size()), 32'h0);
    cfg(32'h0000_0a01, 32'h0, 32'h0);
    exp_q.push_back(32'h15);
    u_far.send(1'b0, 9'h015, 5, 0, 0, 0, 0);
    cfg(32'h0000_1201, 32'h0, 32'h0);
    exp_q.push_back(32'h1a5);
    u_far.send(1'b0, 9'h1a5, 9, 0, 0, 0, 0);
    acq_active_in <= 1'b0;
    u_far.inv = 1'b1;
    u_far.hold(1'b0, 1'b1, 2);
    cfg(32'h0000_1021, 32'h0, 32'h0);
    acq_active_in <= 1'b1;
    base = trig_cnt;
    send_word(8'h96, 0, 0, 0, 0);
    chk_num(trig_cnt - base, 1);
    rd(upt_pkg::A_STAT, (32'(trig_cnt) << 16) | 32'h1);
    rd(upt_pkg::A_CNT, rec_idx);
    summarize();
  end
endmodule

// ===== tb/upt_uart_model.sv
`timescale 1ns/1ps
// ****************************************************
// far-side serial sender
// ****************************************************
module upt_uart_model (
  // clock
  input  wire logic clk_in,
  // serial lines
  output logic      tx_line_out,
  output logic      rx_line_out
);
  int bit_cyc = 16;
  bit inv     = 1'b0; // raw levels inverted for idle-low lines

  // both lines rest at the idle level
  initial begin
    tx_line_out = 1'b1;
    rx_line_out = 1'b1;
  end

  // hold one level on the chosen line for n cycles
  task automatic drive(input bit src, input logic lv, input int n);
    if (src) begin
      rx_line_out <= lv ^ inv;
    end else begin
      tx_line_out <= lv ^ inv;
    end
    repeat (n) @(posedge clk_in);
  endtask

  // raw level for break and glitch cases
  task automatic hold(input bit src, input logic lv, input int n);
    @(posedge clk_in);
    drive(src, lv, n);
  endtask

  // one framed word; bad_par or bad_stop corrupt that bit
  task automatic send(input bit src, input logic [8:0] v, input int nb,
                      input int par, input bit msb, input bit bad_par,
                      input bit bad_stop);
    int   i;
    logic p;
    p = 1'b0;
    @(posedge clk_in);
    drive(src, 1'b0, bit_cyc);
    for (i = 0; i < nb; i++) begin
      drive(src, msb ? v[nb-1-i] : v[i], bit_cyc);
      p = p ^ v[i];
    end
    case (par)
      1: p = ~p;
      3: p = 1'b1;
      4: p = 1'b0;
      default: p = p;
    endcase
    if (par != 0) begin
      drive(src, p ^ bad_par, bit_cyc);
    end
    drive(src, ~bad_stop, bit_cyc);
    drive(src, 1'b1, 2 * bit_cyc);
  endtask
endmodule
